// File: core_model.sv
// Core-side model: issues one request at a time and waits for completion.
// Assumes done and trap pulses from the block last one cycle each.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clk_i,
   input wire logic done_i,
   input wire logic ae_i,
   input wire logic se_i,
   output var dsa_pkg::core_req_t req_o
);
   logic [23:0] pc = 24'h000000;
   logic [7:0] st = 8'h00;
   logic got;
   logic ae;
   logic se;
   initial req_o = '0;
   // Request held one edge only; block never stalls an idle core
   // Callers keep stack-pointer reads off the slot after a limit write
   task automatic issue(input dsa_pkg::op_t op, input dsa_pkg::am_t md,
      input logic b, input logic [3:0] w, input logic [3:0] p,
      input logic [15:0] f);
      @(posedge clk_i);
      req_o <= '{1'b1, op, md, b, w, p, f, pc, st};
      @(posedge clk_i);
      req_o.valid <= 1'b0;
      got = 1'b0;
      ae = 1'b0;
      se = 1'b0;
      for (int i = 0; i < 4 && !got; i++) begin
         @(negedge clk_i);
         ae |= ae_i;
         se |= se_i;
         got = done_i;
      end
   endtask
endmodule
`default_nettype wire

// File: data_space_access.sv
// Data-space access: working registers, byte lanes, stack and traps.
// Assumes one request at a time, offered only while busy_o is low.
//
// What this block does
// RL1 - Data path, working registers and stack limit are sixteen bits, memory byte addressed.
// RL2 - Byte read fetches word, address bit 0 picks byte, low lane out.
// RL3 - One word decode, separate byte write lines for memory and registers.
// RL4 - The Y read path fetches whole words only.
// RL5 - Post-increment adds one for bytes, two for words.
// RL6 - Word access at an odd address raises an address error trap.
// RL7 - Misaligned read completes, misaligned write is dropped except the upper word of a call or exception push, trap pulses with done.
// RL8 - Byte load into a working register changes only its low byte.
// RL9 - Sign extend widens signed byte; zero extend clears the upper byte.
// RL10 - Near direct field of thirteen bits reaches 0x0000 to 0x1FFF.
// RL11 - Move direct field of sixteen bits reaches all of X space.
// RL12 - Register 15 is stack pointer: next free word, grows upward.
// RL13 - Call push forces the upper byte of the upper PC word to zero.
// RL14 - Exception push puts the status low byte in that upper byte.
// RL15 - Stack limit is not reset and its bit 0 reads zero.
// RL16 - Stack addresses compared with limit; push past the limit traps.
// RL17 - Stack address below 0x0800 raises a stack error trap.
// RL18 - Caller avoids stack-pointer reads right after a limit write.
// RL19 - Each trap is a one-cycle request with the faulting context.
`timescale 1ns/1ps
`default_nettype none
module data_space_access #(
   parameter int RAM_DEPTH = 2048
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire dsa_pkg::core_req_t req_i,
   input wire logic y_rd_i,
   input wire logic y_byte_i,
   input wire logic [15:0] y_ea_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   output logic [15:0] x_rdata_o,
   output logic [15:0] y_rdata_o,
   output logic busy_o,
   output logic done_o,
   output logic addr_err_trap_o,
   output logic stack_err_trap_o,
   output dsa_pkg::trap_ctx_t trap_ctx_o,
   output logic irq_o
);
   localparam int IRQ_W_L = dsa_pkg::IRQ_W;
   typedef enum logic [1:0] {S_IDLE, S_READ, S_PUSH_HI} fsm_t;
   typedef struct packed {
      fsm_t fsm;
      logic [15:0][15:0] wreg;
      logic [15:0] stack_limit;
      logic [15:0] pend_ea;
      logic [3:0] pend_dst;
      logic pend_byte;
      logic pend_reg_hit;
      logic [15:0] pend_reg_val;
      logic pend_addr_err;
      logic pend_stack_err;
      logic [15:0] pend_hi;
      logic [15:0] x_rdata;
      logic busy;
      logic done;
      logic addr_err;
      logic stack_err;
      dsa_pkg::trap_ctx_t ctx;
      logic y_err;
      logic [IRQ_W_L-1:0] irq_status;
      logic [IRQ_W_L-1:0] irq_enable;
      logic irq;
      logic [15:0] reg_rdata;
   } state_t;

   state_t st;
   state_t next_st;
   dsa_pkg::ram_wr_t ram_wr;
   logic [15:0] ram_x_rdata;
   logic [15:0] ram_y_rdata;
   logic [15:0] ea;
   logic [15:0] ptr;
   logic [15:0] sp;
   logic [15:0] src;
   logic [4:0] slot;
   logic lim_hit;
   logic take;
   logic mem_op;
   logic is_push;
   logic sp_src;
   logic misalign;
   logic over;
   logic under;

   // Returns {hit, index} for a working register at this address
   function automatic logic [4:0] wreg_slot(input logic [15:0] a);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (a[15:1] == dsa_pkg::WREG_OFF[i][15:1]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] lane_merge(input logic [15:0] old,
      input logic [15:0] d, input logic lo, input logic hi);
      return {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
   endfunction

   stack_check u_stack_check (
      .ea_i(ea),
      .limit_i(st.stack_limit),
      .push_i(is_push),
      .sp_src_i(sp_src),
      .over_o(over),
      .under_o(under)
   );

   word_ram #(
      .DEPTH(RAM_DEPTH)
   ) u_word_ram (
      .core_clk_i(core_clk_i),
      .wr_i(ram_wr),
      .x_ea_i(ea),
      .y_ea_i(y_ea_i),
      .x_rdata_o(ram_x_rdata),
      .y_rdata_o(ram_y_rdata)
   );

   always_comb begin
      logic [15:0] rd;
      logic [15:0] hi_word;
      logic [15:0] wdat;
      logic [IRQ_W_L-1:0] ev;
      rd = 16'h0000;
      hi_word = 16'h0000;
      wdat = 16'h0000;
      ev = '0;
      next_st = st;
      ram_wr = '0;
      sp = st.wreg[dsa_pkg::SP_IDX];
      ptr = st.wreg[req_i.preg];
      src = st.wreg[req_i.wreg];
      take = st.fsm == S_IDLE && req_i.valid;
      is_push = req_i.op inside {dsa_pkg::OP_PUSH, dsa_pkg::OP_CALL_PUSH,
         dsa_pkg::OP_EXC_PUSH};
      mem_op = is_push || req_i.op inside {dsa_pkg::OP_LOAD,
         dsa_pkg::OP_STORE, dsa_pkg::OP_POP};
      case (req_i.mode)
         dsa_pkg::AM_NEAR: ea = {3'b000, // [RL10]
            req_i.field[dsa_pkg::NEAR_W-1:0]};
         dsa_pkg::AM_FULL: ea = req_i.field; // [RL11]
         default: ea = ptr;
      endcase
      sp_src = req_i.preg == dsa_pkg::SP_IDX &&
         req_i.mode inside {dsa_pkg::AM_IND, dsa_pkg::AM_POSTINC};
      if (is_push) begin
         ea = sp;
         sp_src = 1'b1;
      end else if (req_i.op == dsa_pkg::OP_POP) begin
         ea = sp - dsa_pkg::STEP_WORD; // [RL12]
         sp_src = 1'b1;
      end
      // Upper frame word is a pointer-based push too, so it is checked
      if (st.fsm == S_PUSH_HI) begin
         ea = st.pend_ea;
         is_push = 1'b1;
         mem_op = 1'b1;
         sp_src = 1'b1;
      end
      sp_src = sp_src && (take || st.fsm == S_PUSH_HI) && mem_op; // [RL16]
      misalign = take && mem_op && ea[0] &&
         (!req_i.byte_op || req_i.op != dsa_pkg::OP_LOAD &&
         req_i.op != dsa_pkg::OP_STORE); // [RL6]
      slot = wreg_slot(ea);
      lim_hit = ea[15:1] == dsa_pkg::OFF_LIMIT[15:1];
      next_st.done = 1'b0;
      next_st.addr_err = 1'b0;
      next_st.stack_err = 1'b0;
      // Byte or odd fetch on the Y path is refused with a trap
      next_st.y_err = y_rd_i && (y_byte_i || y_ea_i[0]); // [RL4]

      // Software port first so the core's own update below wins a clash
      if (reg_wr_i) begin
         if (wreg_slot(reg_addr_i)[4]) begin
            next_st.wreg[wreg_slot(reg_addr_i)[3:0]] = reg_wdata_i;
         end
         if (reg_addr_i == dsa_pkg::OFF_LIMIT) begin
            next_st.stack_limit = {reg_wdata_i[15:1], 1'b0}; // [RL15]
         end
         if (reg_addr_i == dsa_pkg::OFF_IRQ_CLEAR) begin
            next_st.irq_status = st.irq_status &
               ~reg_wdata_i[IRQ_W_L-1:0];
         end
         if (reg_addr_i == dsa_pkg::OFF_IRQ_ENABLE) begin
            next_st.irq_enable = reg_wdata_i[IRQ_W_L-1:0];
         end
      end
      next_st.reg_rdata = 16'h0000;
      if (reg_rd_i) begin
         if (wreg_slot(reg_addr_i)[4]) begin
            next_st.reg_rdata = st.wreg[wreg_slot(reg_addr_i)[3:0]];
         end else if (reg_addr_i == dsa_pkg::OFF_LIMIT) begin
            next_st.reg_rdata = st.stack_limit;
         end else if (reg_addr_i == dsa_pkg::OFF_IRQ_STATUS) begin
            next_st.reg_rdata = 16'(st.irq_status);
         end else if (reg_addr_i == dsa_pkg::OFF_IRQ_ENABLE) begin
            next_st.reg_rdata = 16'(st.irq_enable);
         end
      end

      case (st.fsm)
         S_IDLE: begin
            if (take) begin
               next_st.pend_ea = ea;
               next_st.pend_dst = req_i.wreg;
               next_st.pend_byte = req_i.byte_op;
               next_st.pend_reg_hit = slot[4] || lim_hit;
               next_st.pend_reg_val = lim_hit ? st.stack_limit :
                  st.wreg[slot[3:0]];
               next_st.pend_addr_err = misalign;
               next_st.pend_stack_err = over || under; // [RL16] [RL17]
               wdat = is_push ? (req_i.op == dsa_pkg::OP_PUSH ? src :
                  req_i.pc[15:0]) : src;
               if (req_i.op == dsa_pkg::OP_STORE && req_i.byte_op) begin
                  wdat = {src[7:0], src[7:0]};
               end
               // Dropped write on a misaligned word store
               if ((req_i.op == dsa_pkg::OP_STORE || is_push) &&
                  !misalign) begin // [RL7]
                  ram_wr.ea = ea;
                  ram_wr.data = wdat;
                  ram_wr.we_lo = !req_i.byte_op || !ea[0]; // [RL3]
                  ram_wr.we_hi = !req_i.byte_op || ea[0];
                  if (slot[4] && req_i.op == dsa_pkg::OP_STORE) begin
                     next_st.wreg[slot[3:0]] = lane_merge(
                        st.wreg[slot[3:0]], wdat, ram_wr.we_lo,
                        ram_wr.we_hi); // [RL3]
                     ram_wr.we_lo = 1'b0;
                     ram_wr.we_hi = 1'b0;
                  end
               end
               if (req_i.mode == dsa_pkg::AM_POSTINC && !is_push &&
                  req_i.op != dsa_pkg::OP_POP) begin
                  next_st.wreg[req_i.preg] = ptr + (req_i.byte_op ?
                     dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD); // [RL5]
               end
               if (is_push) begin
                  next_st.wreg[dsa_pkg::SP_IDX] = sp +
                     dsa_pkg::STEP_WORD; // [RL12]
               end
               if (req_i.op == dsa_pkg::OP_POP) begin
                  next_st.wreg[dsa_pkg::SP_IDX] = ea; // [RL12]
               end
               hi_word = {req_i.op == dsa_pkg::OP_EXC_PUSH ?
                  req_i.status_low : 8'h00, req_i.pc[23:16]}; // [RL13] [RL14]
               next_st.pend_hi = hi_word;
               case (req_i.op)
                  dsa_pkg::OP_LOAD, dsa_pkg::OP_POP: next_st.fsm = S_READ;
                  dsa_pkg::OP_CALL_PUSH, dsa_pkg::OP_EXC_PUSH: begin
                     next_st.fsm = S_PUSH_HI;
                     next_st.pend_ea = sp + dsa_pkg::STEP_WORD;
                  end
                  dsa_pkg::OP_SIGN_EXT: begin
                     next_st.wreg[req_i.wreg] = // [RL9]
                        {{8{src[7]}}, src[7:0]};
                     next_st.done = 1'b1;
                  end
                  dsa_pkg::OP_ZERO_EXT: begin
                     next_st.wreg[req_i.wreg] = {8'h00, src[7:0]}; // [RL9]
                     next_st.done = 1'b1;
                  end
                  default: begin
                     next_st.done = 1'b1;
                     next_st.addr_err = misalign; // [RL7]
                     next_st.stack_err = over || under;
                  end
               endcase
            end
         end
         S_READ: begin
            rd = st.pend_reg_hit ? st.pend_reg_val : ram_x_rdata;
            if (st.pend_byte) begin
               rd = {8'h00, st.pend_ea[0] ? rd[15:8] : rd[7:0]}; // [RL2]
               next_st.wreg[st.pend_dst] = {st.wreg[st.pend_dst][15:8],
                  rd[7:0]}; // [RL8]
            end else begin
               next_st.wreg[st.pend_dst] = rd; // [RL1]
            end
            // Read still completes; trap pulses in the same cycle as done
            next_st.x_rdata = rd;
            next_st.addr_err = st.pend_addr_err; // [RL7]
            next_st.stack_err = st.pend_stack_err;
            next_st.done = 1'b1;
            next_st.fsm = S_IDLE;
         end
         S_PUSH_HI: begin
            ram_wr.ea = st.pend_ea;
            ram_wr.data = st.pend_hi;
            ram_wr.we_lo = 1'b1;
            ram_wr.we_hi = 1'b1;
            next_st.wreg[dsa_pkg::SP_IDX] = sp + dsa_pkg::STEP_WORD;
            next_st.addr_err = st.pend_addr_err;
            next_st.stack_err = st.pend_stack_err || over || under;
            next_st.done = 1'b1;
            next_st.fsm = S_IDLE;
         end
         default: next_st.fsm = S_IDLE;
      endcase

      if (next_st.addr_err || next_st.stack_err) begin
         next_st.ctx.ea = st.fsm == S_IDLE ? ea : st.pend_ea; // [RL19]
         next_st.ctx.write = st.fsm != S_READ;
         next_st.ctx.y_path = 1'b0;
         next_st.ctx.stack = next_st.stack_err;
      end else if (st.y_err) begin
         next_st.ctx = '{ea: 16'h0000, write: 1'b0, y_path: 1'b1,
            stack: 1'b0};
      end
      next_st.addr_err = next_st.addr_err || st.y_err;
      ev[dsa_pkg::ADDR_ERR_BIT] = next_st.addr_err;
      ev[dsa_pkg::STACK_ERR_BIT] = next_st.stack_err;
      next_st.irq_status = next_st.irq_status | ev;
      next_st.irq = |(next_st.irq_status & next_st.irq_enable);
      next_st.busy = next_st.fsm != S_IDLE;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
         st.fsm <= S_IDLE;
         for (int i = 0; i < 16; i++) begin
            st.wreg[i] <= dsa_pkg::RST_WREG;
         end
         st.wreg[dsa_pkg::SP_IDX] <= dsa_pkg::RST_SP;
         st.stack_limit <= next_st.stack_limit; // [RL15]
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_o = st.reg_rdata;
   assign x_rdata_o = st.x_rdata;
   assign y_rdata_o = ram_y_rdata;
   assign busy_o = st.busy;
   assign done_o = st.done;
   assign addr_err_trap_o = st.addr_err;
   assign stack_err_trap_o = st.stack_err;
   assign trap_ctx_o = st.ctx;
   assign irq_o = st.irq;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_odd_word_trap: assert property ( // [RL6]
      take && misalign |-> ##[1:2] addr_err_trap_o)
      else $error("odd word access gave no address error");
   a_misalign_no_write: assert property ( // [RL7]
      take && misalign |-> !ram_wr.we_lo && !ram_wr.we_hi)
      else $error("misaligned write reached memory");
   a_byte_lane_store: assert property ( // [RL3]
      take && req_i.op == dsa_pkg::OP_STORE && req_i.byte_op && !slot[4]
      |-> ram_wr.we_hi == ea[0] && ram_wr.we_lo != ea[0])
      else $error("byte store hit wrong lane");
   a_postinc_step: assert property ( // [RL5]
      take && req_i.mode == dsa_pkg::AM_POSTINC && req_i.byte_op &&
      req_i.op inside {dsa_pkg::OP_LOAD, dsa_pkg::OP_STORE} && !reg_wr_i
      |=> st.wreg[$past(req_i.preg)] == $past(ptr) + 16'h0001)
      else $error("byte post-increment step wrong");
   a_push_sp_step: assert property ( // [RL12]
      take && req_i.op == dsa_pkg::OP_PUSH && !reg_wr_i
      |=> sp == $past(sp) + 16'h0002 ##1 !$stable(done_o) || done_o)
      else $error("push did not advance pointer by one word");
   a_push_at_limit: assert property ( // [RL16]
      take && req_i.op == dsa_pkg::OP_PUSH && sp == st.stack_limit &&
      sp >= 16'h0800 |=> !stack_err_trap_o)
      else $error("push at the limit trapped");
   a_floor_trap: assert property ( // [RL17]
      take && sp_src && ea < 16'h0800 |-> ##[1:2] stack_err_trap_o)
      else $error("stack address under floor gave no trap");
   a_limit_lsb: assert property ( // [RL15]
      reg_wr_i && reg_addr_i == dsa_pkg::OFF_LIMIT
      |=> st.stack_limit == {$past(reg_wdata_i[15:1]), 1'b0})
      else $error("limit write kept bit 0");
   a_sign_extend: assert property ( // [RL9]
      take && req_i.op == dsa_pkg::OP_SIGN_EXT && !reg_wr_i
      |=> st.wreg[$past(req_i.wreg)] == {{8{$past(src[7])}}, $past(src[7:0])})
      else $error("sign extend result wrong");
   a_call_hi_zero: assert property ( // [RL13]
      take && req_i.op == dsa_pkg::OP_CALL_PUSH
      |=> ram_wr.we_hi && ram_wr.data[15:8] == 8'h00)
      else $error("call push upper byte not zero");
   a_trap_with_done: assert property ( // [RL19]
      stack_err_trap_o || addr_err_trap_o && !trap_ctx_o.y_path |-> done_o)
      else $error("trap pulse without completing access");
endmodule
`default_nettype wire

// File: dsa_pkg.sv
// Shared constants and carriers for the data-space access block.
// Assumes one core clock; nothing here holds state.
package dsa_pkg;
   localparam int DATA_W = 16;
   localparam int NEAR_W = 13;
   localparam logic [15:0] WREG_OFF [16] = '{
      16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h8000, 16'h000A,
      16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
      16'h0018, 16'h001A, 16'h001C, 16'h001E};
   localparam logic [15:0] OFF_LIMIT = 16'h0020;
   localparam logic [15:0] OFF_IRQ_STATUS = 16'h0060;
   localparam logic [15:0] OFF_IRQ_CLEAR = 16'h0062;
   localparam logic [15:0] OFF_IRQ_ENABLE = 16'h0064;
   localparam logic [15:0] RST_WREG = 16'h0000;
   localparam logic [15:0] RST_SP = 16'h0800;
   localparam logic [15:0] SP_FLOOR = 16'h0800;
   localparam logic [15:0] RAM_BASE = 16'h0800;
   localparam logic [3:0] SP_IDX = 4'hF;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   localparam int IRQ_W = 2;
   localparam int ADDR_ERR_BIT = 0;
   localparam int STACK_ERR_BIT = 1;
   typedef enum logic [3:0] {OP_NONE, OP_LOAD, OP_STORE, OP_PUSH, OP_POP,
      OP_CALL_PUSH, OP_EXC_PUSH, OP_SIGN_EXT, OP_ZERO_EXT} op_t;
   typedef enum logic [1:0] {AM_NEAR, AM_FULL, AM_IND, AM_POSTINC} am_t;
   typedef struct packed {
      logic valid;
      op_t op;
      am_t mode;
      logic byte_op;
      logic [3:0] wreg;
      logic [3:0] preg;
      logic [15:0] field;
      logic [23:0] pc;
      logic [7:0] status_low;
   } core_req_t;
   typedef struct packed {
      logic [15:0] ea;
      logic write;
      logic y_path;
      logic stack;
   } trap_ctx_t;
   typedef struct packed {
      logic we_lo;
      logic we_hi;
      logic [15:0] ea;
      logic [15:0] data;
   } ram_wr_t;
endpackage

// File: stack_check.sv
// Stack limit and floor comparison for addresses formed from the pointer.
// Assumes the caller only raises sp_src_i for such addresses.
`timescale 1ns/1ps
`default_nettype none
module stack_check (
   input wire logic [15:0] ea_i,
   input wire logic [15:0] limit_i,
   input wire logic push_i,
   input wire logic sp_src_i,
   output logic over_o,
   output logic under_o
);
   // Push at the limit itself is legal; the one after it is not
   assign over_o = sp_src_i && push_i && (ea_i > limit_i);
   assign under_o = sp_src_i && (ea_i < dsa_pkg::SP_FLOOR);
endmodule
`default_nettype wire

// File: test_data_space_access.sv
// Self-checking bench for the data-space access block.
// Assumes a small RAM of 64 words from 0x0800 and the core model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_data_space_access;
   localparam dsa_pkg::op_t LD = dsa_pkg::OP_LOAD, ST = dsa_pkg::OP_STORE;
   localparam dsa_pkg::op_t PU = dsa_pkg::OP_PUSH, PO = dsa_pkg::OP_POP;
   localparam dsa_pkg::op_t CP = dsa_pkg::OP_CALL_PUSH;
   localparam dsa_pkg::op_t EP = dsa_pkg::OP_EXC_PUSH;
   localparam dsa_pkg::op_t SX = dsa_pkg::OP_SIGN_EXT;
   localparam dsa_pkg::op_t ZX = dsa_pkg::OP_ZERO_EXT;
   localparam dsa_pkg::am_t NR = dsa_pkg::AM_NEAR, FU = dsa_pkg::AM_FULL;
   localparam dsa_pkg::am_t IN = dsa_pkg::AM_IND, PI = dsa_pkg::AM_POSTINC;
   logic clk, rst_n, y_rd, y_byte, wr, rd, busy, done, ae, se, irq;
   logic [15:0] y_ea, addr, wd, rdata, xd, yd;
   dsa_pkg::core_req_t req;
   dsa_pkg::trap_ctx_t ctx;
   int n_errors = 0;
   int total_checks = 0;
   core_model core (.clk_i(clk), .done_i(done), .ae_i(ae), .se_i(se),
      .req_o(req));
   data_space_access #(.RAM_DEPTH(64)) DUT (.core_clk_i(clk),
      .rst_n_i(rst_n), .req_i(req), .y_rd_i(y_rd), .y_byte_i(y_byte),
      .y_ea_i(y_ea), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .x_rdata_o(xd), .y_rdata_o(yd),
      .busy_o(busy), .done_o(done), .addr_err_trap_o(ae),
      .stack_err_trap_o(se), .trap_ctx_o(ctx), .irq_o(irq));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bw(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic br(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask
   task automatic yr(input logic [15:0] a, input logic b);
      @(posedge clk);
      y_ea <= a;
      y_byte <= b;
      y_rd <= 1'b1;
      @(posedge clk);
      y_rd <= 1'b0;
      y_byte <= 1'b0;
      @(negedge clk);
   endtask
   // Completion plus both trap flags compared as one word
   task automatic run(input dsa_pkg::op_t op, input dsa_pkg::am_t md,
      input logic b, input logic [3:0] w, input logic [3:0] p,
      input logic [15:0] f, input logic ea, input logic es);
      core.issue(op, md, b, w, p, f);
      check(16'({core.got, core.ae, core.se}), 16'({1'b1, ea, es}));
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Whole run is a little over a hundred cycles
   initial begin
      #100000;
      n_errors++;
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      y_rd = 1'b0;
      y_byte = 1'b0;
      y_ea = 16'h0000;
      addr = 16'h0000;
      wd = 16'h0000;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      br(16'h001E, dsa_pkg::RST_SP);
      br(16'h0000, 16'h0000);
      br(16'h0040, 16'h0000);
      bw(16'h0002, 16'hA55A);
      br(16'h0002, 16'hA55A);
      bw(dsa_pkg::OFF_LIMIT, 16'h0803);
      br(dsa_pkg::OFF_LIMIT, 16'h0802);
      $display("test registers finished");
      run(ST, FU, '0, 4'h1, '0, 16'h0810, '0, '0);
      run(LD, FU, '1, 4'h2, '0, 16'h0811, '0, '0);
      check(xd, 16'h00A5);
      bw(16'h0006, 16'h33C7);
      run(ST, FU, '1, 4'h3, '0, 16'h0810, '0, '0);
      run(LD, NR, '0, 4'h2, '0, 16'hE810, '0, '0);
      check(xd, 16'hA5C7);
      run(LD, FU, '1, 4'h3, '0, 16'h0811, '0, '0);
      br(16'h0006, 16'h33A5);
      run(SX, IN, '0, 4'h3, '0, '0, '0, '0);
      br(16'h0006, 16'hFFA5);
      run(ZX, IN, '0, 4'h3, '0, '0, '0, '0);
      br(16'h0006, 16'h00A5);
      bw(16'h000A, 16'h0810);
      run(LD, PI, '1, 4'h2, 4'h5, '0, '0, '0);
      br(16'h000A, 16'h0811);
      run(LD, PI, '0, 4'h2, 4'h5, '0, '1, '0);
      check(ctx.ea, 16'h0811);
      run(ST, FU, '0, 4'h1, '0, 16'h0811, '1, '0);
      check(16'(ctx.write), 16'h0001);
      run(LD, FU, '0, 4'h2, '0, 16'h0810, '0, '0);
      check(xd, 16'hA5C7);
      $display("test lanes finished");
      run(PU, IN, '0, 4'h1, '0, '0, '0, '0);
      run(PU, IN, '0, 4'h1, '0, '0, '0, '0);
      run(PU, IN, '0, 4'h1, '0, '0, '0, '1);
      br(16'h001E, 16'h0806);
      bw(dsa_pkg::OFF_LIMIT, 16'h0870);
      br(16'h0000, 16'h0000);
      core.pc = 24'hAB1234;
      core.st = 8'h5C;
      run(CP, IN, '0, '0, '0, '0, '0, '0);
      run(EP, IN, '0, '0, '0, '0, '0, '0);
      run(LD, FU, '0, 4'h2, '0, 16'h0806, '0, '0);
      check(xd, 16'h1234);
      run(LD, FU, '0, 4'h2, '0, 16'h0808, '0, '0);
      check(xd, 16'h00AB);
      run(LD, FU, '0, 4'h2, '0, 16'h080C, '0, '0);
      check(xd, 16'h5CAB);
      run(PO, IN, '0, 4'h6, '0, '0, '0, '0);
      br(16'h000C, 16'h5CAB);
      br(16'h001E, 16'h080C);
      bw(16'h001E, 16'h0800);
      run(PO, IN, '0, 4'h6, '0, '0, '0, '1);
      check(16'(ctx.stack), 16'h0001);
      $display("test stack finished");
      yr(16'h0810, 1'b0);
      check(yd, 16'hA5C7);
      yr(16'h0810, 1'b1);
      // Refusal is registered once more, so the trap lands a cycle later
      @(negedge clk);
      check(16'({ae, ctx.y_path}), 16'h0003);
      br(dsa_pkg::OFF_IRQ_STATUS, 16'h0003);
      bw(dsa_pkg::OFF_IRQ_ENABLE, 16'h0001);
      repeat (2) @(negedge clk);
      check(16'(irq), 16'h0001);
      bw(dsa_pkg::OFF_IRQ_CLEAR, 16'h0001);
      repeat (2) @(negedge clk);
      check(16'(irq), 16'h0000);
      br(dsa_pkg::OFF_IRQ_STATUS, 16'h0002);
      $display("test y path and interrupt finished");
      final_report();
   end
endmodule
`default_nettype wire

// File: word_ram.sv
// Byte-laned data RAM with one write port and two registered read ports.
// Assumes byte addresses; outside the array both reads give zero.
`timescale 1ns/1ps
`default_nettype none
module word_ram #(
   parameter int DEPTH = 2048
) (
   input wire logic core_clk_i,
   input wire dsa_pkg::ram_wr_t wr_i,
   input wire logic [15:0] x_ea_i,
   input wire logic [15:0] y_ea_i,
   output logic [15:0] x_rdata_o,
   output logic [15:0] y_rdata_o
);
   logic [7:0] lo_mem [DEPTH];
   logic [7:0] hi_mem [DEPTH];

   function automatic logic in_ram(input logic [15:0] ea);
      return ea >= dsa_pkg::RAM_BASE &&
         ((ea - dsa_pkg::RAM_BASE) >> 1) < 16'(DEPTH);
   endfunction

   function automatic int unsigned idx(input logic [15:0] ea);
      return int'((ea - dsa_pkg::RAM_BASE) >> 1);
   endfunction

   // Shared word decode, one write line per byte lane
   always_ff @(posedge core_clk_i) begin
      if (in_ram(wr_i.ea) && wr_i.we_lo) begin
         lo_mem[idx(wr_i.ea)] <= wr_i.data[7:0];
      end
      if (in_ram(wr_i.ea) && wr_i.we_hi) begin
         hi_mem[idx(wr_i.ea)] <= wr_i.data[15:8];
      end
      x_rdata_o <= in_ram(x_ea_i) ?
         {hi_mem[idx(x_ea_i)], lo_mem[idx(x_ea_i)]} : 16'h0000;
      y_rdata_o <= in_ram(y_ea_i) ?
         {hi_mem[idx(y_ea_i)], lo_mem[idx(y_ea_i)]} : 16'h0000;
   end
endmodule
`default_nettype wire
